// ### rtl/otm_pkg.sv
// Constants, register map and types for the trace and payload-type monitor
package otm_pkg;

   // Field sizes
   localparam int unsigned TTI_LEN   = 64;
   localparam int unsigned PSI_LEN   = 255;
   localparam int unsigned AUTO_LEN  = 13;
   localparam int unsigned ADDR_W    = 8;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_PT     = 8'h04;
   localparam logic [7:0] REG_NODE   = 8'h08;
   localparam logic [7:0] REG_LOC    = 8'h0C;
   localparam logic [7:0] REG_ACC    = 8'h10;
   localparam logic [7:0] REG_DATA   = 8'h14;
   localparam logic [7:0] REG_LEN    = 8'h18;
   localparam logic [7:0] REG_CMD    = 8'h1C;
   localparam logic [7:0] REG_STAT   = 8'h20;

   // Control bit positions
   localparam int unsigned CTL_PT_TX_AUTO  = 0;
   localparam int unsigned CTL_PT_EXP_AUTO = 1;
   localparam int unsigned CTL_EN_LSB      = 2;
   localparam int unsigned CTL_SQ_LSB      = 6;
   localparam int unsigned CTL_GFP         = 10;
   localparam logic [31:0] CTRL_RST        = 32'h0000_0023;
   localparam logic [31:0] CTRL_MASK       = 32'h0000_07FF;

   // Field positions in PT, LOC, ACC, LEN, CMD and STAT
   localparam int unsigned PT_EXP_LSB   = 8;
   localparam int unsigned LOC_SLOT_LSB = 0;
   localparam int unsigned LOC_MDA_LSB  = 4;
   localparam int unsigned LOC_PORT_LSB = 8;
   localparam int unsigned LOC_CHAN_LSB = 12;
   localparam int unsigned ACC_IDX_LSB  = 8;
   localparam int unsigned ACC_SEL_LSB  = 16;
   localparam int unsigned ACC_WR_BIT   = 31;
   localparam int unsigned CMD_COPY_BIT = 0;
   localparam int unsigned STAT_RPT_LSB = 4;
   localparam int unsigned STAT_SQ_BIT  = 8;
   localparam int unsigned STAT_CP_BIT  = 9;

   // Byte codes
   localparam logic [7:0] PT_PLAIN  = 8'h03;
   localparam logic [7:0] PT_GFP    = 8'h05;
   localparam logic [7:0] TTI_ESC   = 8'hFF;
   localparam logic [7:0] CH_COLON  = 8'h3A;
   localparam logic [7:0] CH_SLASH  = 8'h2F;
   localparam logic [7:0] CH_ZERO   = 8'h30;
   localparam logic [7:0] MF_FIRST  = 8'h00;
   localparam logic [7:0] MF_LAST   = 8'hFF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // Trace store selectors
   typedef enum logic [2:0] {
      SEL_TX_SM   = 3'b000,
      SEL_TX_PM   = 3'b001,
      SEL_TX_PSI  = 3'b010,
      SEL_EXP_SM  = 3'b011,
      SEL_EXP_PM  = 3'b100,
      SEL_EXP_PSI = 3'b101
   } otm_sel_t;

   typedef enum logic [1:0] {
      CP_IDLE = 2'b00,
      CP_WAIT = 2'b01,
      CP_RUN  = 2'b10
   } otm_copy_t;

endpackage

// ### rtl/otm_trace_monitor.sv
// Trail trace and payload type insertion and monitoring with AHB-Lite registers
//
// Summary of operation
// - Path trace up to 64 bytes sent in ODU overhead.
// - Section trace up to 64 bytes sent in OTU overhead.
// - Positions beyond configured length are sent as zero.
// - Single byte 0xFF configured selects the generated default trace.
// - Default trace: node:slot/adapter/port/channel.
// - Clearing transmit config (length zero) restores default trace.
// - Payload type sent in PSI byte 0; default 3, or 5 for GFP.
// - Automatic mode sends standard code, else configured value.
// - PSI trace in positions 1 to 255, zero filled, default zeros.
// - Path trace compared with expected; alarm reported when enabled.
// - Copy request loads received traces into expected storage.
// - Path mismatch passes traffic unless blocking selected.
// - PSI trace compared with expected; alarm reported when enabled.
// - PSI trace mismatch passes or blocks per reaction.
// - Payload type compared with expected; alarm reported when enabled.
// - Payload type mismatch passes or blocks per reaction.
// - Automatic expected mode compares with standard code.
// - Section trace compared with expected; alarm when enabled.
// - Section mismatch blocks traffic when blocking selected.
`timescale 1ns/1ps
`default_nettype none

module otm_trace_monitor #(
   parameter int unsigned DATA_W = 64
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              hsel_i,
   input  wire logic [31:0]       haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [2:0]        hsize_i,
   input  wire logic [31:0]       hwdata_i,
   input  wire logic              hready_i,
   output logic                   hreadyout_o,
   output logic                   hresp_o,
   output logic [31:0]            hrdata_o,
   input  wire logic [7:0]        tx_mfas_i,
   output logic [7:0]             sm_tx_o,
   output logic [7:0]             pm_tx_o,
   output logic [7:0]             psi_tx_o,
   input  wire logic              rx_valid_i,
   input  wire logic [7:0]        rx_mfas_i,
   input  wire logic [7:0]        rx_sm_i,
   input  wire logic [7:0]        rx_pm_i,
   input  wire logic [7:0]        rx_psi_i,
   input  wire logic [DATA_W-1:0] rx_data_i,
   input  wire logic              rx_data_vld_i,
   output logic [DATA_W-1:0]      rx_data_o,
   output logic                   rx_data_vld_o,
   output logic                   sm_tim_o,
   output logic                   pm_tim_o,
   output logic                   psi_tim_o,
   output logic                   plm_o,
   output logic                   squelch_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage and declarations
   logic [7:0]             mem_ff [0:5][0:255];
   logic [8:0]             len_ff [0:5];
   logic [31:0]            ctrl_ff;
   logic [31:0]            pt_ff;
   logic [31:0]            node_ff;
   logic [19:0]            loc_ff;
   logic [18:0]            acc_ff;
   logic                   dp_wr_ff;
   logic                   dp_rd_ff;
   logic [7:0]             dp_addr_ff;
   logic                   dp_map_ff;
   logic [31:0]            hrdata_ff;
   otm_pkg::otm_copy_t     cp_st_ff;
   logic [3:0]             acc_miss_ff;
   logic [3:0]             mis_ff;
   logic [3:0]             rpt_ff;
   logic [7:0]             sm_tx_ff;
   logic [7:0]             pm_tx_ff;
   logic [7:0]             psi_tx_ff;
   logic [DATA_W-1:0]      rx_data_ff;
   logic                   rx_vld_ff;
   logic                   wr_en;
   logic                   rd_acc;
   logic [2:0]             acc_sel;
   logic [7:0]             acc_idx;
   logic                   cp_go;
   logic                   cp_done;
   logic                   mf_end;
   logic [3:0]             miss_w;
   logic [3:0]             en_w;
   logic [3:0]             sq_sel_w;
   logic                   squelch_w;
   logic [7:0]             pt_tx_w;
   logic [7:0]             pt_exp_w;
   logic [7:0]             auto_w;
   localparam int unsigned AUTO_W = 8 * otm_pkg::AUTO_LEN;
   logic [AUTO_W-1:0]      auto_vec;

   assign acc_sel = acc_ff[otm_pkg::ACC_SEL_LSB +: 3];
   assign acc_idx = acc_ff[otm_pkg::ACC_IDX_LSB +: 8];

   // Byte of a stored field, zero outside the configured length
   function automatic logic [7:0] field_byte(input logic [7:0] b, input logic [7:0] pos,
                                             input logic [8:0] len, input logic base1);
      logic [8:0] rel;
      rel = {1'b0, pos} - {8'h00, base1};
      field_byte = ((pos != otm_pkg::MF_FIRST || !base1) && rel < len) ? b : 8'h00;
   endfunction

   // Field length limit per store
   function automatic logic [8:0] max_len(input logic [2:0] sel);
      if (sel == otm_pkg::SEL_TX_PSI || sel == otm_pkg::SEL_EXP_PSI) begin
         max_len = 9'(otm_pkg::PSI_LEN);
      end else begin
         max_len = 9'(otm_pkg::TTI_LEN);
      end
   endfunction

   // Transmit trace byte with default-trace selection
   function automatic logic [7:0] tx_tti(input logic [2:0] sel, input logic [5:0] pos);
      if (len_ff[sel] == 9'h000 ||
          (len_ff[sel] == 9'h001 && mem_ff[sel][0] == otm_pkg::TTI_ESC)) begin
         tx_tti = auto_w;
      end else begin
         tx_tti = field_byte(mem_ff[sel][{2'b00, pos}], {2'b00, pos}, len_ff[sel], 1'b0);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave
   assign wr_en       = dp_wr_ff && dp_map_ff;
   assign hreadyout_o = !dp_rd_ff;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_ff;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dp_wr_ff   <= 1'b0;
         dp_rd_ff   <= 1'b0;
         dp_addr_ff <= 8'h00;
         dp_map_ff  <= 1'b0;
      end else begin
         dp_rd_ff <= 1'b0;
         dp_wr_ff <= 1'b0;
         if (hsel_i && hready_i && htrans_i == otm_pkg::HTRANS_NONSEQ) begin
            dp_wr_ff   <= hwrite_i && hsize_i == 3'b010;
            dp_rd_ff   <= !hwrite_i;
            dp_addr_ff <= haddr_i[otm_pkg::ADDR_W-1:0];
            dp_map_ff  <= haddr_i[31:otm_pkg::ADDR_W] == 24'h00_0000;
         end
      end
   end

   // Read data registered in the single wait state
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (dp_rd_ff) begin
         hrdata_ff <= 32'h0000_0000;
         if (dp_map_ff) begin
            case (dp_addr_ff)
               otm_pkg::REG_CTRL: hrdata_ff <= ctrl_ff;
               otm_pkg::REG_PT:   hrdata_ff <= pt_ff;
               otm_pkg::REG_NODE: hrdata_ff <= node_ff;
               otm_pkg::REG_LOC:  hrdata_ff <= {12'h000, loc_ff};
               otm_pkg::REG_ACC:  hrdata_ff <= {13'h0000, acc_ff};
               otm_pkg::REG_DATA: hrdata_ff <= (acc_sel <= otm_pkg::SEL_EXP_PSI) ?
                                               {24'h00_0000, mem_ff[acc_sel][acc_idx]} :
                                               32'h0000_0000;
               otm_pkg::REG_LEN:  hrdata_ff <= (acc_sel <= otm_pkg::SEL_EXP_PSI) ?
                                               {23'h00_0000, len_ff[acc_sel]} :
                                               32'h0000_0000;
               otm_pkg::REG_STAT: hrdata_ff <= {22'h00_0000, cp_st_ff != otm_pkg::CP_IDLE,
                                                squelch_w, rpt_ff, mis_ff};
               default:           hrdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   assign rd_acc = wr_en && dp_addr_ff == otm_pkg::REG_ACC;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= otm_pkg::CTRL_RST;
         pt_ff   <= {16'h0000, otm_pkg::PT_PLAIN, otm_pkg::PT_PLAIN};
         node_ff <= 32'h0000_0000;
         loc_ff  <= 20'h0_0000;
         acc_ff  <= 19'h0_0000;
      end else if (wr_en) begin
         case (dp_addr_ff)
            otm_pkg::REG_CTRL: ctrl_ff <= hwdata_i & otm_pkg::CTRL_MASK;
            otm_pkg::REG_PT:   pt_ff   <= {16'h0000, hwdata_i[15:0]};
            otm_pkg::REG_NODE: node_ff <= hwdata_i;
            otm_pkg::REG_LOC:  loc_ff  <= hwdata_i[19:0];
            otm_pkg::REG_ACC:  acc_ff  <= hwdata_i[18:0];
            otm_pkg::REG_LEN:  acc_ff  <= {hwdata_i[18:16], acc_ff[15:0]};
            default:           acc_ff  <= acc_ff;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trace stores
   always_ff @(posedge sys_clk_i) begin
      if (rd_acc && hwdata_i[otm_pkg::ACC_WR_BIT] &&
          hwdata_i[otm_pkg::ACC_SEL_LSB +: 3] <= otm_pkg::SEL_EXP_PSI) begin
         mem_ff[hwdata_i[otm_pkg::ACC_SEL_LSB +: 3]][hwdata_i[otm_pkg::ACC_IDX_LSB +: 8]]
            <= hwdata_i[7:0];
      end
      if (cp_go) begin
         mem_ff[otm_pkg::SEL_EXP_SM][{2'b00, rx_mfas_i[5:0]}] <= rx_sm_i;
         mem_ff[otm_pkg::SEL_EXP_PM][{2'b00, rx_mfas_i[5:0]}] <= rx_pm_i;
         mem_ff[otm_pkg::SEL_EXP_PSI][rx_mfas_i]              <= rx_psi_i;
      end
   end

   // length zero means cleared; expected zero after reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 6; i++) begin
            len_ff[i] <= 9'h000;
         end
      end else begin
         if (wr_en && dp_addr_ff == otm_pkg::REG_LEN &&
             hwdata_i[otm_pkg::ACC_SEL_LSB +: 3] <= otm_pkg::SEL_EXP_PSI) begin
            len_ff[hwdata_i[otm_pkg::ACC_SEL_LSB +: 3]] <=
               (hwdata_i[8:0] > max_len(hwdata_i[otm_pkg::ACC_SEL_LSB +: 3])) ?
               max_len(hwdata_i[otm_pkg::ACC_SEL_LSB +: 3]) : hwdata_i[8:0];
         end
         if (cp_done) begin
            len_ff[otm_pkg::SEL_EXP_SM]  <= 9'(otm_pkg::TTI_LEN);
            len_ff[otm_pkg::SEL_EXP_PM]  <= 9'(otm_pkg::TTI_LEN);
            len_ff[otm_pkg::SEL_EXP_PSI] <= 9'(otm_pkg::PSI_LEN);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Copy-received sequencer, one whole multiframe
   assign cp_go   = rx_valid_i && ((cp_st_ff == otm_pkg::CP_WAIT && rx_mfas_i == otm_pkg::MF_FIRST)
                                   || cp_st_ff == otm_pkg::CP_RUN);
   assign cp_done = rx_valid_i && cp_st_ff == otm_pkg::CP_RUN && rx_mfas_i == otm_pkg::MF_LAST;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cp_st_ff <= otm_pkg::CP_IDLE;
      end else begin
         case (cp_st_ff)
            otm_pkg::CP_IDLE: begin
               if (wr_en && dp_addr_ff == otm_pkg::REG_CMD &&
                   hwdata_i[otm_pkg::CMD_COPY_BIT]) begin
                  cp_st_ff <= otm_pkg::CP_WAIT;
               end
            end
            otm_pkg::CP_WAIT: begin
               if (cp_go) begin
                  cp_st_ff <= otm_pkg::CP_RUN;
               end
            end
            otm_pkg::CP_RUN: begin
               if (cp_done) begin
                  cp_st_ff <= otm_pkg::CP_IDLE;
               end
            end
            default: cp_st_ff <= otm_pkg::CP_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit overhead insertion
   // default trace layout
   assign auto_vec = {node_ff, otm_pkg::CH_COLON,
                      otm_pkg::CH_ZERO + {4'h0, loc_ff[otm_pkg::LOC_SLOT_LSB +: 4]},
                      otm_pkg::CH_SLASH,
                      otm_pkg::CH_ZERO + {4'h0, loc_ff[otm_pkg::LOC_MDA_LSB +: 4]},
                      otm_pkg::CH_SLASH,
                      otm_pkg::CH_ZERO + {4'h0, loc_ff[otm_pkg::LOC_PORT_LSB +: 4]},
                      otm_pkg::CH_SLASH,
                      otm_pkg::CH_ZERO + {4'h0, loc_ff[otm_pkg::LOC_CHAN_LSB + 4 +: 4]},
                      otm_pkg::CH_ZERO + {4'h0, loc_ff[otm_pkg::LOC_CHAN_LSB +: 4]}};
   assign auto_w = (tx_mfas_i[5:0] < 6'(otm_pkg::AUTO_LEN)) ?
                   auto_vec[(otm_pkg::AUTO_LEN - 1 - 32'(tx_mfas_i[5:0])) * 8 +: 8] : 8'h00;
   assign pt_tx_w = ctrl_ff[otm_pkg::CTL_PT_TX_AUTO] ?
                    (ctrl_ff[otm_pkg::CTL_GFP] ? otm_pkg::PT_GFP : otm_pkg::PT_PLAIN) : pt_ff[7:0];

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sm_tx_ff  <= 8'h00;
         pm_tx_ff  <= 8'h00;
         psi_tx_ff <= 8'h00;
      end else begin
         sm_tx_ff  <= tx_tti(otm_pkg::SEL_TX_SM, tx_mfas_i[5:0]);
         pm_tx_ff  <= tx_tti(otm_pkg::SEL_TX_PM, tx_mfas_i[5:0]);
         psi_tx_ff <= (tx_mfas_i == otm_pkg::MF_FIRST) ? pt_tx_w :
                      field_byte(mem_ff[otm_pkg::SEL_TX_PSI][tx_mfas_i], tx_mfas_i,
                                 len_ff[otm_pkg::SEL_TX_PSI], 1'b1);
      end
   end

   assign sm_tx_o  = sm_tx_ff;
   assign pm_tx_o  = pm_tx_ff;
   assign psi_tx_o = psi_tx_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Receive comparison, per multiframe
   // expected payload type
   assign pt_exp_w = ctrl_ff[otm_pkg::CTL_PT_EXP_AUTO] ?
                     (ctrl_ff[otm_pkg::CTL_GFP] ? otm_pkg::PT_GFP : otm_pkg::PT_PLAIN) :
                     pt_ff[otm_pkg::PT_EXP_LSB +: 8];
   assign mf_end   = rx_valid_i && rx_mfas_i == otm_pkg::MF_LAST;
   assign miss_w[0] = rx_sm_i != field_byte(mem_ff[otm_pkg::SEL_EXP_SM][{2'b00, rx_mfas_i[5:0]}],
                      {2'b00, rx_mfas_i[5:0]}, len_ff[otm_pkg::SEL_EXP_SM], 1'b0);
   assign miss_w[1] = rx_pm_i != field_byte(mem_ff[otm_pkg::SEL_EXP_PM][{2'b00, rx_mfas_i[5:0]}],
                      {2'b00, rx_mfas_i[5:0]}, len_ff[otm_pkg::SEL_EXP_PM], 1'b0);
   assign miss_w[2] = rx_mfas_i != otm_pkg::MF_FIRST &&
                      rx_psi_i != field_byte(mem_ff[otm_pkg::SEL_EXP_PSI][rx_mfas_i], rx_mfas_i,
                                             len_ff[otm_pkg::SEL_EXP_PSI], 1'b1);
   assign miss_w[3] = rx_mfas_i == otm_pkg::MF_FIRST && rx_psi_i != pt_exp_w;
   assign en_w      = ctrl_ff[otm_pkg::CTL_EN_LSB +: 4];
   assign sq_sel_w  = ctrl_ff[otm_pkg::CTL_SQ_LSB +: 4];
   assign squelch_w = |(mis_ff & sq_sel_w);

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_miss_ff <= 4'h0;
         mis_ff      <= 4'h0;
      end else if (rx_valid_i) begin
         if (mf_end) begin
            mis_ff[2:0] <= acc_miss_ff[2:0] | miss_w[2:0];
            acc_miss_ff <= 4'h0;
         end else begin
            acc_miss_ff <= acc_miss_ff | miss_w;
         end
         if (rx_mfas_i == otm_pkg::MF_FIRST) begin
            mis_ff[3] <= miss_w[3];
         end
      end
   end

   // Alarms reported only when enabled
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rpt_ff <= 4'h0;
      end else begin
         rpt_ff <= mis_ff & en_w;
      end
   end

   assign sm_tim_o  = rpt_ff[0];
   assign pm_tim_o  = rpt_ff[1];
   assign psi_tim_o = rpt_ff[2];
   assign plm_o     = rpt_ff[3];
   assign squelch_o = squelch_w;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_data_ff <= '0;
         rx_vld_ff  <= 1'b0;
      end else begin
         rx_data_ff <= squelch_w ? '0 : rx_data_i;
         rx_vld_ff  <= rx_data_vld_i && !squelch_w;
      end
   end

   assign rx_data_o     = rx_data_ff;
   assign rx_data_vld_o = rx_vld_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_mf_end_bad(int k);
      mf_end && (acc_miss_ff[k] || miss_w[k]);
   endsequence

   sequence s_mf_end_clean;
      mf_end && acc_miss_ff[2:0] == 3'b000 && miss_w[2:0] == 3'b000;
   endsequence

   sequence s_rd_accept;
      hsel_i && hready_i && htrans_i == otm_pkg::HTRANS_NONSEQ && !hwrite_i;
   endsequence

   AST_RD_WAIT: assert property (s_rd_accept |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait state wrong");
   AST_ZERO_FILL: assert property ((len_ff[otm_pkg::SEL_TX_PM] > 9'h001 ||
         (len_ff[otm_pkg::SEL_TX_PM] == 9'h001 &&
          mem_ff[otm_pkg::SEL_TX_PM][0] != otm_pkg::TTI_ESC)) &&
         {3'b000, tx_mfas_i[5:0]} >= len_ff[otm_pkg::SEL_TX_PM] |=> pm_tx_o == 8'h00)
      else $error("path trace padding not zero");
   AST_FF_DEFAULT: assert property (len_ff[otm_pkg::SEL_TX_PM] == 9'h001 &&
         mem_ff[otm_pkg::SEL_TX_PM][0] == otm_pkg::TTI_ESC |=> pm_tx_o == $past(auto_w))
      else $error("escape byte did not select default");
   AST_PT_BYTE0: assert property (tx_mfas_i == otm_pkg::MF_FIRST |=>
         psi_tx_o == $past(pt_tx_w))
      else $error("payload type not in byte 0");
   AST_PT_AUTO: assert property (tx_mfas_i == otm_pkg::MF_FIRST &&
         ctrl_ff[otm_pkg::CTL_PT_TX_AUTO] && !ctrl_ff[otm_pkg::CTL_GFP] |=>
         psi_tx_o == otm_pkg::PT_PLAIN)
      else $error("automatic payload type wrong");
   AST_SM_TIM: assert property (s_mf_end_bad(0) |=>
         mis_ff[0] ##1 (rpt_ff[0] == $past(en_w[0])))
      else $error("section mismatch not raised");
   AST_PM_TIM: assert property (s_mf_end_bad(1) |=> mis_ff[1])
      else $error("path mismatch not raised");
   AST_PSI_TIM: assert property (s_mf_end_bad(2) |=> mis_ff[2])
      else $error("PSI mismatch not raised");
   AST_TIM_CLEAR: assert property (s_mf_end_clean |=> mis_ff[2:0] == 3'b000)
      else $error("mismatch did not clear");
   AST_PLM: assert property (rx_valid_i && rx_mfas_i == otm_pkg::MF_FIRST &&
         rx_psi_i != pt_exp_w |=> mis_ff[3])
      else $error("payload type mismatch missed");
   AST_SQUELCH: assert property (squelch_w |=> !rx_data_vld_o)
      else $error("traffic not blocked");
   AST_PASS: assert property (!squelch_w |=> rx_data_vld_o == $past(rx_data_vld_i))
      else $error("traffic not passed");
   AST_COPY_LEN: assert property (cp_done |=>
         len_ff[otm_pkg::SEL_EXP_PSI] == 9'(otm_pkg::PSI_LEN) && cp_st_ff == otm_pkg::CP_IDLE)
      else $error("copy did not finish");

endmodule // otm_trace_monitor

`default_nettype wire

// ### test/otm_far_framer.sv
// Remote framer model sending overhead multiframes
`timescale 1ns/1ps
`default_nettype none
module otm_far_framer (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] pt_i,
   input  wire logic       bad_i,
   output logic            valid_o,
   output logic [7:0]      mfas_o,
   output logic [7:0]      sm_o,
   output logic [7:0]      pm_o,
   output logic [7:0]      psi_o
);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         mfas_o  <= 8'h00;
      end else begin
         valid_o <= 1'b1;
         mfas_o  <= valid_o ? mfas_o + 8'h01 : 8'h00;
      end
   end
   assign sm_o = (bad_i && mfas_o[5:0] == 6'h07) ? 8'hC3 : 8'h00;
   assign pm_o = (bad_i && mfas_o[5:0] == 6'h05) ? 8'h5A : 8'h00;
   // type in position 0, trace byte 9 corrupt
   assign psi_o = (mfas_o == 8'h00) ? pt_i : ((bad_i && mfas_o == 8'h09) ? 8'h96 : 8'h00);
endmodule // otm_far_framer
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the trace and payload-type monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [63:0] DAT = 64'h0123_4567_89AB_CDEF;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [7:0]  tx_mfas = 8'h00;
   logic [7:0]  pt = 8'h03;
   logic        bad = 1'b0;
   logic [31:0] hrdata, q;
   logic [7:0]  sm_tx, pm_tx, psi_tx, r_mfas, r_sm, r_pm, r_psi;
   logic [63:0] rx_dout;
   logic        hready, hresp, r_vld, rx_dvld, sm_tim, pm_tim, psi_tim, plm, squelch;
   int          n_mismatch = 0;
   int          num_checks = 0;
   otm_trace_monitor otm_trace_monitor_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
      .hrdata_o(hrdata), .tx_mfas_i(tx_mfas), .sm_tx_o(sm_tx), .pm_tx_o(pm_tx),
      .psi_tx_o(psi_tx), .rx_valid_i(r_vld), .rx_mfas_i(r_mfas), .rx_sm_i(r_sm),
      .rx_pm_i(r_pm), .rx_psi_i(r_psi), .rx_data_i(DAT), .rx_data_vld_i(1'b1),
      .rx_data_o(rx_dout), .rx_data_vld_o(rx_dvld), .sm_tim_o(sm_tim), .pm_tim_o(pm_tim),
      .psi_tim_o(psi_tim), .plm_o(plm), .squelch_o(squelch));
   otm_far_framer otm_far_framer_inst (.clk_i(clk), .rst_n_i(rst_n), .pt_i(pt), .bad_i(bad),
      .valid_o(r_vld), .mfas_o(r_mfas), .sm_o(r_sm), .pm_o(r_pm), .psi_o(r_psi));
   always #2.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // Byte registered at first edge, seen before second edge updates
   task automatic tx(input logic [7:0] m);
      tx_mfas <= m;
      repeat (2) @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #100us;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, otm_pkg::REG_CTRL, 32'h0000_0000);
      chk(q, otm_pkg::CTRL_RST);
      bus(1'b0, otm_pkg::REG_PT, 32'h0000_0000);
      chk(q, 32'h0000_0303);
      bus(1'b0, 8'hFC, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      tx(8'h00);
      chk({24'h00_0000, psi_tx}, {24'h00_0000, otm_pkg::PT_PLAIN});
      bus(1'b1, otm_pkg::REG_NODE, 32'h4142_4344);
      bus(1'b1, otm_pkg::REG_LOC, 32'h0004_5321);
      tx(8'h04);
      chk({24'h00_0000, pm_tx}, {24'h00_0000, otm_pkg::CH_COLON});
      tx(8'h4C);
      chk({24'h00_0000, sm_tx}, 32'h0000_0035);
      tx(8'h0D);
      chk({24'h00_0000, sm_tx}, 32'h0000_0000);
      bus(1'b1, otm_pkg::REG_ACC, 32'h8001_00FF);
      bus(1'b1, otm_pkg::REG_LEN, 32'h0001_0001);
      tx(8'h04);
      chk({24'h00_0000, pm_tx}, {24'h00_0000, otm_pkg::CH_COLON});
      bus(1'b1, otm_pkg::REG_ACC, 32'h8001_0055);
      tx(8'h40);
      chk({24'h00_0000, pm_tx}, 32'h0000_0055);
      tx(8'h04);
      chk({24'h00_0000, pm_tx}, 32'h0000_0000);
      bus(1'b1, otm_pkg::REG_LEN, 32'h0001_0000);
      tx(8'h04);
      chk({24'h00_0000, pm_tx}, {24'h00_0000, otm_pkg::CH_COLON});
      bus(1'b1, otm_pkg::REG_PT, 32'h0000_0347);
      bus(1'b1, otm_pkg::REG_CTRL, 32'h0000_0022);
      tx(8'h00);
      chk({24'h00_0000, psi_tx}, 32'h0000_0047);
      tx(8'h01);
      chk({24'h00_0000, psi_tx}, 32'h0000_0000);
      bus(1'b1, otm_pkg::REG_CTRL, 32'h0000_00AB);
      bad <= 1'b1;
      repeat (600) @(posedge clk);
      chk({30'h0, pm_tim, squelch}, 32'h0000_0003);
      chk({31'h0, rx_dvld}, 32'h0000_0000);
      bad <= 1'b0;
      repeat (600) @(posedge clk);
      chk({30'h0, pm_tim, squelch}, 32'h0000_0000);
      chk(rx_dout[31:0], DAT[31:0]);
      pt <= 8'h05;
      repeat (600) @(posedge clk);
      chk({30'h0, plm, squelch}, 32'h0000_0002);
      bus(1'b1, otm_pkg::REG_CTRL, 32'h0000_04AB);
      repeat (600) @(posedge clk);
      chk({31'h0, plm}, 32'h0000_0000);
      tx(8'h00);
      chk({24'h00_0000, psi_tx}, {24'h00_0000, otm_pkg::PT_GFP});
      bad <= 1'b1;
      bus(1'b1, otm_pkg::REG_CMD, 32'h0000_0001);
      repeat (1200) @(posedge clk);
      chk({31'h0, pm_tim}, 32'h0000_0000);
      bad <= 1'b0;
      repeat (600) @(posedge clk);
      chk({31'h0, pm_tim}, 32'h0000_0001);
      bus(1'b1, otm_pkg::REG_CTRL, 32'h0000_04BF);
      repeat (600) @(posedge clk);
      chk({28'h0, sm_tim, pm_tim, psi_tim, hresp}, 32'h0000_000E);
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
